// ===== verilog/spi_crc_pkg.sv
package spi_crc_pkg;

  // ==========================================================================
  // checksum
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_PRESET = 8'hA5;

  // ==========================================================================
  // framing
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;

  // ==========================================================================
  // register offsets
  localparam logic [14:0] OFS_SETUP_A = 15'h0000;
  localparam logic [14:0] OFS_SETUP_B = 15'h0001;
  localparam logic [14:0] OFS_POWER = 15'h0002;
  localparam logic [14:0] OFS_SCRATCH = 15'h000A;
  localparam logic [14:0] OFS_TPAT_BASE = 15'h0038;
  localparam logic [14:0] TPAT_STRIDE = 15'h0012;
  localparam logic [14:0] ADDR_FIRST = 15'h0000;
  localparam logic [14:0] ADDR_LAST = 15'h00B9;
  localparam int CHANNELS = 8;
  localparam int TPAT_BYTES = 4;

  // ==========================================================================
  // reset values and writable masks
  localparam logic [7:0] RST_SETUP_A = 8'h00;
  localparam logic [7:0] RST_SETUP_B = 8'h00;
  localparam logic [7:0] RST_POWER = 8'hF0;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] MASK_SETUP_A = 8'h30;
  localparam logic [7:0] MASK_SETUP_B = 8'h80;
  localparam logic [7:0] MASK_POWER = 8'h03;
  localparam logic [7:0] MASK_SCRATCH = 8'hFF;
  localparam logic [23:0] TPAT_LOW = 24'hCE3C2A;
  localparam logic [3:0] TPAT_TAG = 4'hA;

  // ==========================================================================
  // field positions
  localparam int BIT_SOFT_RESET_HIGH = 7;
  localparam int BIT_ADDR_ASCEND = 5;
  localparam int BIT_FOUR_WIRE = 4;
  localparam int BIT_SOFT_RESET_LOW = 0;
  localparam int BIT_SINGLE_ACCESS = 7;
  localparam int POWER_LSB = 0;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    PH_INSTR = 3'b001,
    PH_DATA = 3'b010,
    PH_CHECK = 3'b100
  } phase_t;

  typedef struct packed {
    logic isRead;
    logic [14:0] addr;
  } instr_t;

  typedef struct packed {
    logic selN;
    logic sclk;
    logic sdi;
  } pins_t;

  localparam pins_t PINS_IDLE = '{selN: 1'b1, sclk: 1'b0, sdi: 1'b0};

endpackage

// ===== verilog/crc8_byte.sv
`timescale 1ns/10ps
module crc8_byte #(
  parameter logic [7:0] POLY = spi_crc_pkg::CRC_POLY,
  parameter logic [7:0] PRESET = spi_crc_pkg::CRC_PRESET
) (
  // byte in, checksum out
  input wire logic [7:0] data,
  output logic [7:0] crc
);

  // ==========================================================================
  // msb first, no reflection, no final inversion
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc = PRESET;
    for (int i = 7; i >= 0; i--) begin
      fb = crc[7] ^ data[i];
      crc = {crc[6:0], 1'b0} ^ (fb ? POLY : 8'h00);
    end
  end

endmodule

// ===== verilog/spi_register_crc_check.sv
`timescale 1ns/10ps
// Contract
// - with checking on, each data byte is followed by its checksum byte
// - checksum covers only the register data byte moved
// - checksum mismatch makes that register access invalid
// - checksum polynomial is x^8 + x^2 + x + 1
// - checksum starts from 0xA5 for every transaction
// - registers are one byte; unmapped addresses are reserved
// - registers reset to defaults; bits obey their access mode
// - eight channel register groups share one layout
// - with checking on, writes commit only after a valid checksum
module spi_register_crc_check (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // configuration serial bus pins
  input wire logic cfgSelN,
  input wire logic configSerialClock,
  input wire logic configSerialIoIn,
  output logic configSerialIoOut,
  output logic configSerialIoOe,
  output logic cfgDataOut,
  output logic cfgDataOe,
  // checking control and status
  input wire logic crcEnable,
  output logic crcMismatch,
  // configuration to the rest of the device
  output logic fourWireSelect,
  output logic addrAscending,
  output logic singleAccessFraming,
  output logic [1:0] powerStateSelect,
  output logic softResetPulse
);

  // ==========================================================================
  // pin synchronisers and edge detect
  spi_crc_pkg::pins_t sync1_ff, sync2_ff;
  logic sclkPrev_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_ff <= spi_crc_pkg::PINS_IDLE;
      sync2_ff <= spi_crc_pkg::PINS_IDLE;
      sclkPrev_ff <= 1'b0;
    end else begin
      sync1_ff <= '{selN: cfgSelN, sclk: configSerialClock, sdi: configSerialIoIn};
      sync2_ff <= sync1_ff;
      sclkPrev_ff <= sync2_ff.sclk;
    end
  end

  wire frameOn = !sync2_ff.selN;
  wire riseEv = frameOn & sync2_ff.sclk & !sclkPrev_ff;
  wire fallEv = frameOn & !sync2_ff.sclk & sclkPrev_ff;

  // ==========================================================================
  // frame state
  spi_crc_pkg::phase_t phase_ff, nxt_phase;
  logic [3:0] bitCnt_ff, nxt_bitCnt;
  logic [14:0] instSr_ff;
  logic [7:0] rxSr_ff, wrByte_ff, rdByte_ff, outSr_ff, pendByte_ff;
  logic pend_ff, fetch_ff, mismatch_ff;
  spi_crc_pkg::instr_t cmd_ff;
  logic [7:0] crcOut, rdData;
  logic [7:0] setupA_ff, setupB_ff, power_ff, scratch_ff;

  wire [7:0] rxByte = {rxSr_ff[6:0], sync2_ff.sdi};
  wire spi_crc_pkg::instr_t instWord = spi_crc_pkg::instr_t'({instSr_ff, sync2_ff.sdi});
  wire inInstr = phase_ff == spi_crc_pkg::PH_INSTR;
  wire lastInstr = riseEv & inInstr & (bitCnt_ff == spi_crc_pkg::INSTR_LAST_BIT);
  wire lastByte = riseEv & !inInstr & (bitCnt_ff == spi_crc_pkg::BYTE_LAST_BIT);
  wire dataDone = lastByte & (phase_ff == spi_crc_pkg::PH_DATA);
  wire checkDone = lastByte & (phase_ff == spi_crc_pkg::PH_CHECK);
  wire needCheck = dataDone & crcEnable;
  wire byteEnd = (dataDone & !crcEnable) | checkDone;
  wire streaming = !singleAccessFraming;
  wire crcGood = rxByte == crcOut;
  wire isWrite = !cmd_ff.isRead;
  wire commitEn = isWrite & ((dataDone & !crcEnable) | (checkDone & crcGood));
  wire [7:0] commitData = crcEnable ? wrByte_ff : rxByte;
  wire [7:0] crcData = cmd_ff.isRead ? rdByte_ff : wrByte_ff;
  wire readOut = frameOn & cmd_ff.isRead & !inInstr;

  wire atLast = cmd_ff.addr == spi_crc_pkg::ADDR_LAST;
  wire atFirst = cmd_ff.addr == spi_crc_pkg::ADDR_FIRST;
  wire [14:0] addrUp = atLast ? spi_crc_pkg::ADDR_FIRST : 15'(cmd_ff.addr + 15'h0001);
  wire [14:0] addrDown = atFirst ? spi_crc_pkg::ADDR_LAST : 15'(cmd_ff.addr - 15'h0001);
  wire [14:0] nextAddr = addrAscending ? addrUp : addrDown;

  crc8_byte #(
    .POLY(spi_crc_pkg::CRC_POLY),
    .PRESET(spi_crc_pkg::CRC_PRESET)
  ) u_crc (
    .data(crcData),
    .crc(crcOut)
  );

  always_comb begin
    nxt_phase = phase_ff;
    if (!frameOn) begin
      nxt_phase = spi_crc_pkg::PH_INSTR;
    end else if (lastInstr) begin
      nxt_phase = spi_crc_pkg::PH_DATA;
    end else if (needCheck) begin
      nxt_phase = spi_crc_pkg::PH_CHECK;
    end else if (byteEnd) begin
      nxt_phase = streaming ? spi_crc_pkg::PH_DATA : spi_crc_pkg::PH_INSTR;
    end
  end

  always_comb begin
    nxt_bitCnt = bitCnt_ff;
    if (!frameOn || lastInstr || lastByte) begin
      nxt_bitCnt = 4'h0;
    end else if (riseEv) begin
      nxt_bitCnt = 4'(bitCnt_ff + 4'h1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      phase_ff <= spi_crc_pkg::PH_INSTR;
      bitCnt_ff <= 4'h0;
      instSr_ff <= 15'h0000;
      rxSr_ff <= 8'h00;
    end else begin
      phase_ff <= nxt_phase;
      bitCnt_ff <= nxt_bitCnt;
      if (riseEv && inInstr) begin
        instSr_ff <= {instSr_ff[13:0], sync2_ff.sdi};
      end
      if (riseEv) begin
        rxSr_ff <= rxByte;
      end
    end
  end

  // ==========================================================================
  // command, received byte and checksum result
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_ff <= '0;
      wrByte_ff <= 8'h00;
      mismatch_ff <= 1'b0;
      fetch_ff <= 1'b0;
    end else begin
      if (lastInstr) begin
        cmd_ff <= instWord;
      end else if (byteEnd && streaming) begin
        cmd_ff.addr <= nextAddr;
      end
      if (dataDone) begin
        wrByte_ff <= rxByte;
      end
      mismatch_ff <= checkDone & isWrite & !crcGood;
      fetch_ff <= (lastInstr & instWord.isRead) | (byteEnd & streaming & cmd_ff.isRead);
    end
  end

  // ==========================================================================
  // read data out: loaded on the fall after a phase ends, shifted on falls
  always_ff @(posedge clock) begin
    if (reset) begin
      rdByte_ff <= 8'h00;
      pendByte_ff <= 8'h00;
      pend_ff <= 1'b0;
      outSr_ff <= 8'h00;
    end else begin
      if (fetch_ff) begin
        rdByte_ff <= rdData;
      end
      if (!frameOn) begin
        pend_ff <= 1'b0;
      end else if (fetch_ff) begin
        pendByte_ff <= rdData;
        pend_ff <= 1'b1;
      end else if (needCheck && cmd_ff.isRead) begin
        pendByte_ff <= crcOut;
        pend_ff <= 1'b1;
      end else if (fallEv) begin
        pend_ff <= 1'b0;
      end
      if (fallEv) begin
        outSr_ff <= pend_ff ? pendByte_ff : {outSr_ff[6:0], 1'b0};
      end
    end
  end

  assign configSerialIoOut = outSr_ff[7];
  assign cfgDataOut = outSr_ff[7];
  assign configSerialIoOe = readOut & !fourWireSelect;
  assign cfgDataOe = readOut & fourWireSelect;
  assign crcMismatch = mismatch_ff;

  // ==========================================================================
  // register file
  wire hitA = cmd_ff.addr == spi_crc_pkg::OFS_SETUP_A;
  wire hitB = cmd_ff.addr == spi_crc_pkg::OFS_SETUP_B;
  wire hitPower = cmd_ff.addr == spi_crc_pkg::OFS_POWER;
  wire hitScratch = cmd_ff.addr == spi_crc_pkg::OFS_SCRATCH;
  wire softReset = commitEn & hitA & commitData[spi_crc_pkg::BIT_SOFT_RESET_HIGH]
    & commitData[spi_crc_pkg::BIT_SOFT_RESET_LOW];
  wire regClear = reset | softReset;

  // soft reset bits read back as zero: they are not stored
  always_ff @(posedge clock) begin
    if (regClear) begin
      setupA_ff <= spi_crc_pkg::RST_SETUP_A;
      setupB_ff <= spi_crc_pkg::RST_SETUP_B;
      power_ff <= spi_crc_pkg::RST_POWER;
      scratch_ff <= spi_crc_pkg::RST_SCRATCH;
    end else if (commitEn) begin
      if (hitA) begin
        setupA_ff <= commitData & spi_crc_pkg::MASK_SETUP_A;
      end
      if (hitB) begin
        setupB_ff <= commitData & spi_crc_pkg::MASK_SETUP_B;
      end
      if (hitPower) begin
        power_ff <= (spi_crc_pkg::RST_POWER & ~spi_crc_pkg::MASK_POWER)
          | (commitData & spi_crc_pkg::MASK_POWER);
      end
      if (hitScratch) begin
        scratch_ff <= commitData & spi_crc_pkg::MASK_SCRATCH;
      end
    end
  end

  // per-channel test pattern bytes, low byte at the lowest address
  localparam int TPAT_N = spi_crc_pkg::CHANNELS * spi_crc_pkg::TPAT_BYTES;
  logic [7:0] tpat_ff [TPAT_N];
  logic [TPAT_N-1:0] tpatHit;
  logic [TPAT_N-1:0][7:0] tpatDef;

  for (genvar ch = 0; ch < spi_crc_pkg::CHANNELS; ch++) begin : g_chan
    for (genvar b = 0; b < spi_crc_pkg::TPAT_BYTES; b++) begin : g_byte
      localparam int IDX = ch * spi_crc_pkg::TPAT_BYTES + b;
      localparam logic [14:0] ADR = 15'(spi_crc_pkg::OFS_TPAT_BASE
        + 15'(ch) * spi_crc_pkg::TPAT_STRIDE + 15'(b));
      localparam logic [31:0] DEF = {4'(ch), spi_crc_pkg::TPAT_TAG, spi_crc_pkg::TPAT_LOW};
      assign tpatHit[IDX] = cmd_ff.addr == ADR;
      assign tpatDef[IDX] = DEF[8*b +: 8];
    end
  end

  // one process owns the whole pattern array
  always_ff @(posedge clock) begin
    for (int i = 0; i < TPAT_N; i++) begin
      if (regClear) begin
        tpat_ff[i] <= tpatDef[i];
      end else if (commitEn && tpatHit[i]) begin
        tpat_ff[i] <= commitData;
      end
    end
  end

  // ==========================================================================
  // read selection; reserved addresses read as zero and ignore writes
  logic [7:0] tpatRd;

  always_comb begin
    tpatRd = 8'h00;
    for (int i = 0; i < TPAT_N; i++) begin
      tpatRd = tpatRd | (tpatHit[i] ? tpat_ff[i] : 8'h00);
    end
  end

  assign rdData = hitA ? setupA_ff :
                  hitB ? setupB_ff :
                  hitPower ? power_ff :
                  hitScratch ? scratch_ff :
                  tpatRd;

  // ==========================================================================
  // configuration outputs
  assign fourWireSelect = setupA_ff[spi_crc_pkg::BIT_FOUR_WIRE];
  assign addrAscending = setupA_ff[spi_crc_pkg::BIT_ADDR_ASCEND];
  assign singleAccessFraming = setupB_ff[spi_crc_pkg::BIT_SINGLE_ACCESS];
  assign powerStateSelect = power_ff[spi_crc_pkg::POWER_LSB +: 2];
  assign softResetPulse = softReset;

endmodule

// ===== sim/spi_register_crc_check_chk.sv
`timescale 1ns/10ps
module spi_register_crc_check_chk (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // watched ports
  input wire logic cfgSelN,
  input wire logic configSerialIoOe,
  input wire logic cfgDataOe,
  input wire logic crcEnable,
  input wire logic crcMismatch,
  input wire logic fourWireSelect,
  input wire logic addrAscending,
  input wire logic [1:0] powerStateSelect,
  input wire logic softResetPulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ====
  // sequences
  sequence sDeselected;
    cfgSelN [*5];
  endsequence
  sequence sDefaults;
    !fourWireSelect && !addrAscending && powerStateSelect == 2'h0;
  endsequence
  // ====
  // assertions
  AST_RESET_DEFAULTS: assert property (disable iff (1'h0) reset |=> sDefaults)
    else $error("outputs not at defaults after reset");
  AST_SRST_DEFAULTS: assert property (softResetPulse |=> ##[0:2] sDefaults)
    else $error("soft reset left settings changed");
  AST_SRST_ONE: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse too long");
  AST_MIS_ONE: assert property (crcMismatch |=> !crcMismatch)
    else $error("mismatch pulse too long");
  AST_MIS_ENABLED: assert property (crcMismatch |-> crcEnable)
    else $error("mismatch without checking on");
  AST_MIS_NO_COMMIT: assert property (crcMismatch |-> powerStateSelect == $past(powerStateSelect, 4))
    else $error("bad checksum write committed");
  AST_COMMIT_IN_FRAME: assert property (!$stable(powerStateSelect) |-> !$past(cfgSelN, 3))
    else $error("register changed outside a frame");
  AST_FOUR_WIRE_OE: assert property (cfgDataOe |-> fourWireSelect && !configSerialIoOe)
    else $error("wrong output pin driven");
  AST_OE_IDLE: assert property (sDeselected |-> !configSerialIoOe && !cfgDataOe)
    else $error("pin driven while deselected");
endmodule

bind spi_register_crc_check spi_register_crc_check_chk chk (.clock, .reset, .cfgSelN,
  .configSerialIoOe, .cfgDataOe, .crcEnable, .crcMismatch, .fourWireSelect, .addrAscending,
  .powerStateSelect, .softResetPulse);

// ===== sim/cfg_host_model.sv
`timescale 1ns/10ps
module cfg_host_model (
  // clock
  input wire logic clock,
  // bus pins
  output spi_crc_pkg::pins_t pins,
  input wire logic ioOut,
  input wire logic ioOe,
  input wire logic dOut,
  input wire logic dOe
);
  wire logic lineIn = ioOe ? ioOut : (dOe ? dOut : pins.sdi);
  initial pins = spi_crc_pkg::PINS_IDLE;

  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c;
    c = spi_crc_pkg::CRC_PRESET;
    for (int i = 7; i >= 0; i--) begin
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? spi_crc_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // one 400 ns serial clock period; sample just before the rise
  task automatic bitx(input logic b, output logic r);
    @(posedge clock);
    pins.sclk <= 1'h0;
    pins.sdi <= b;
    repeat (4) @(posedge clock);
    r = lineIn;
    pins.sclk <= 1'h1;
    repeat (3) @(posedge clock);
  endtask

  task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
  endtask

  // released line carries a toggling pattern on reads
  task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] w,
    input logic crcOn, input logic bad, output logic [7:0] r, output logic [7:0] rc);
    logic [7:0] junk;
    @(posedge clock);
    pins.selN <= 1'h0;
    xbyte({rd, a[14:8]}, junk);
    xbyte(a[7:0], junk);
    xbyte(rd ? 8'h5A : w, r);
    if (crcOn) xbyte(rd ? 8'hA5 : crc8(w) ^ {7'h00, bad}, rc);
    close_frame();
  endtask

  // two reads in one frame: streamed, or with a second instruction when single
  task automatic frame2(input logic [14:0] a, input logic single, input logic [14:0] a1,
    output logic [7:0] r0, output logic [7:0] r1);
    logic [7:0] junk;
    @(posedge clock);
    pins.selN <= 1'h0;
    xbyte({1'h1, a[14:8]}, junk);
    xbyte(a[7:0], junk);
    xbyte(8'h5A, r0);
    if (single) begin
      xbyte({1'h1, a1[14:8]}, junk);
      xbyte(a1[7:0], junk);
    end
    xbyte(8'h5A, r1);
    close_frame();
  endtask

  // park the clock low, then deselect
  task automatic close_frame();
    repeat (4) @(posedge clock);
    pins.sclk <= 1'h0;
    repeat (4) @(posedge clock);
    pins <= spi_crc_pkg::PINS_IDLE;
    repeat (8) @(posedge clock);
  endtask
endmodule

// ===== sim/spi_register_crc_check_tb_top.sv
`timescale 1ns/10ps
module spi_register_crc_check_tb_top;
  typedef struct packed {
    logic rd;
    logic [14:0] addr;
    logic [7:0] data;
    logic crc;
    logic bad;
  } row_t;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic crcEnable = 1'h0;
  spi_crc_pkg::pins_t pins;
  logic ioOut, ioOe, dOut, dOe, mis, fourW, asc, single, srst;
  logic [1:0] pwr;
  logic [7:0] r, rc;
  int fails = 0;
  int compares = 0;
  int misCount = 0;
  int srstCount = 0;
  int m0;
  wire logic ioIn = ioOe ? ioOut : pins.sdi;
  // ====
  // reads carry expected data, writes the value sent
  row_t rows [17] = '{
    '{1'h1, 15'h0002, 8'hF0, 1'h0, 1'h0}, '{1'h1, 15'h0000, 8'h00, 1'h1, 1'h0},
    '{1'h1, 15'h0038, 8'h2A, 1'h1, 1'h0}, '{1'h1, 15'h003B, 8'h0A, 1'h1, 1'h0},
    '{1'h1, 15'h00B9, 8'h7A, 1'h1, 1'h0}, '{1'h0, 15'h000A, 8'h55, 1'h1, 1'h0},
    '{1'h1, 15'h000A, 8'h55, 1'h1, 1'h0}, '{1'h0, 15'h0002, 8'hF1, 1'h1, 1'h1},
    '{1'h1, 15'h0002, 8'hF0, 1'h1, 1'h0}, '{1'h0, 15'h0007, 8'hFF, 1'h0, 1'h0},
    '{1'h1, 15'h0007, 8'h00, 1'h0, 1'h0}, '{1'h0, 15'h0002, 8'hFF, 1'h0, 1'h0},
    '{1'h1, 15'h0002, 8'hF3, 1'h0, 1'h0}, '{1'h0, 15'h000A, 8'h12, 1'h0, 1'h0},
    '{1'h1, 15'h000A, 8'h12, 1'h1, 1'h0}, '{1'h0, 15'h0000, 8'h30, 1'h1, 1'h0},
    '{1'h1, 15'h0000, 8'h30, 1'h1, 1'h0}};

  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (mis) misCount++;
    if (srst) srstCount++;
  end

  spi_register_crc_check dut (
    .clock(clock), .reset(reset), .cfgSelN(pins.selN), .configSerialClock(pins.sclk),
    .configSerialIoIn(ioIn), .configSerialIoOut(ioOut), .configSerialIoOe(ioOe),
    .cfgDataOut(dOut), .cfgDataOe(dOe), .crcEnable(crcEnable), .crcMismatch(mis),
    .fourWireSelect(fourW), .addrAscending(asc), .singleAccessFraming(single),
    .powerStateSelect(pwr), .softResetPulse(srst));
  cfg_host_model host (.clock(clock), .pins(pins), .ioOut(ioOut), .ioOe(ioOe), .dOut(dOut),
    .dOe(dOe));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ====
  // sequence
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 17; i++) begin
      m0 = misCount;
      crcEnable <= rows[i].crc;
      host.frame(rows[i].rd, rows[i].addr, rows[i].data, rows[i].crc, rows[i].bad, r, rc);
      if (rows[i].rd) check("read data", r, rows[i].data);
      if (rows[i].rd && rows[i].crc) check("checksum", rc, host.crc8(rows[i].data));
      if (!rows[i].rd) check("mismatches", 8'(misCount - m0), {7'h00, rows[i].bad});
    end
    check("settings", {5'h00, single, asc, fourW}, 8'h03);
    check("power", {6'h00, pwr}, 8'h03);
    // streaming both ways across the wrap point, then single-access framing
    crcEnable <= 1'h0;
    host.frame2(15'h00B9, 1'h0, 15'h0000, r, rc);
    check("stream up first", r, 8'h7A);
    check("stream up wrap", rc, 8'h30);
    host.frame(1'h0, 15'h0000, 8'h10, 1'h0, 1'h0, r, rc);
    host.frame2(15'h0000, 1'h0, 15'h0000, r, rc);
    check("stream down first", r, 8'h10);
    check("stream down wrap", rc, 8'h7A);
    host.frame(1'h0, 15'h0001, 8'h80, 1'h0, 1'h0, r, rc);
    host.frame2(15'h000A, 1'h1, 15'h0038, r, rc);
    check("single first", r, 8'h12);
    check("single second", rc, 8'h2A);
    check("settings", {5'h00, single, asc, fourW}, 8'h05);
    crcEnable <= 1'h1;
    host.frame(1'h0, 15'h0000, 8'h81, 1'h1, 1'h0, r, rc);
    check("soft resets", 8'(srstCount), 8'h01);
    check("power", {6'h00, pwr}, 8'h00);
    check("settings", {5'h00, single, asc, fourW}, 8'h00);
    host.frame(1'h1, 15'h000A, 8'h00, 1'h1, 1'h0, r, rc);
    check("scratch", r, 8'h00);
    host.frame(1'h0, 15'h000A, 8'h77, 1'h1, 1'h0, r, rc);
    reset <= 1'h1;
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    repeat (4) @(posedge clock);
    host.frame(1'h1, 15'h000A, 8'h00, 1'h1, 1'h0, r, rc);
    check("scratch", r, 8'h00);
    conclude();
  end

  // about 26 frames of about 260 clocks each, well below this
  initial begin
    #1000000;
    fails++;
    conclude();
  end
endmodule
